// ### codec_ctrl_defines.svh
// offsets, write masks, reset values, field positions and counts of the control bank
`ifndef CODEC_CTRL_DEFINES_SVH
`define CODEC_CTRL_DEFINES_SVH
`define COMPAND_OFS  7'h05
`define COMPAND_MSK  9'h03F
`define COMPAND_RST  9'h000
`define CLKGEN_OFS   7'h06
`define CLKGEN_MSK   9'h1FD
`define CLKGEN_RST   9'h140
`define RATE_OFS     7'h07
`define RATE_MSK     9'h00F
`define RATE_RST     9'h000
`define PIN_OFS      7'h08
`define PIN_MSK      9'h03F
`define PIN_RST      9'h000
`define JDCFG_OFS    7'h09
`define JDCFG_MSK    9'h1F0
`define JDCFG_RST    9'h000
`define DACCTL_OFS   7'h0A
`define DACCTL_MSK   9'h04F
`define DACCTL_RST   9'h000
`define PVOLL_OFS    7'h0B
`define PVOLR_OFS    7'h0C
`define JDMASK_OFS   7'h0D
`define JDMASK_MSK   9'h0FF
`define JDMASK_RST   9'h000
`define ADCCTL_OFS   7'h0E
`define ADCCTL_MSK   9'h1FB
`define ADCCTL_RST   9'h100
`define RVOLL_OFS    7'h0F
`define RVOLR_OFS    7'h10
`define VOL_MSK      9'h0FF
`define VOL_RST      9'h0FF
`define EQ1_OFS      7'h12
`define EQ1_RST      9'h12C
`define EQ2_OFS      7'h13
`define EQ3_OFS      7'h14
`define EQ4_OFS      7'h15
`define EQ_MSK       9'h17F
`define EQ_RST       9'h02C
`define EQ5_OFS      7'h16
`define EQ5_MSK      9'h07F
`define LIMT_OFS     7'h18
`define LIMT_MSK     9'h1FF
`define LIMT_RST     9'h032
`define LIML_OFS     7'h19
`define LIML_MSK     9'h07F
`define LIML_RST     9'h000
`define NOTCH_OFS    7'h1B
`define NOTCH_MSK    9'h0FF
`define NOTCH_RST    9'h000
`define STATUS_OFS   7'h3F
`define F_VU         8
`define F_GAIN       7:0
`define LIM_LVL_MAX  3'h6
`define LIM_BOOST_MAX 4'hC
`define JACK_INPUT_SEL_RSVD  2'h3
`define SLOW_DIV_DEF 4096
`define DEB_TICKS_DEF 4
`endif

// ### codec_ctrl_pkg.sv
// types shared by the codec control bank
package codec_ctrl_pkg;
	typedef enum logic [1:0] {CMP_LINEAR, CMP_MU_LAW, CMP_A_LAW} compand_t;
	typedef enum {IX_COMP, IX_CLK, IX_RATE, IX_PIN, IX_JDCFG, IX_DACCTL, IX_PVOLL, IX_PVOLR,
		IX_JDMASK, IX_ADCCTL, IX_RVOLL, IX_RVOLR, IX_EQ1, IX_EQ2, IX_EQ3, IX_EQ4, IX_EQ5,
		IX_LIMT, IX_LIML, IX_NOTCH, IX_NUM} reg_ix_t;
	typedef struct packed {
		logic           eight_bit_mode;
		compand_t       play_compand;
		compand_t       rec_compand;
		logic           loopback;
		logic           core_clock_source_sel;
		logic [2:0]     sys_clock_divider;
		logic [2:0]     bit_clock_divider;
		logic [2:0]     rate_coefficient_sel;
		logic           slow_tick_enable;
		logic           slow_tick;
		logic [1:0]     jack_midrail_enables;
		logic           soft_mute;
		logic           auto_mute;
		logic [2:0]     play_flags;
		logic [2:0]     rec_flags;
		logic [7:0]     playback_left_gain;
		logic [7:0]     playback_right_gain;
		logic [7:0]     record_left_gain;
		logic [7:0]     record_right_gain;
		logic           highpass_enable;
		logic           highpass_mode_sel;
		logic [2:0]     highpass_cutoff_sel;
		logic           eq_path_sel;
		logic [4:0][8:0] eq_bands;
		logic           limiter_enable;
		logic [3:0]     limiter_decay_sel;
		logic [3:0]     limiter_attack_sel;
		logic [2:0]     limiter_threshold_db;
		logic [3:0]     limiter_gain_boost;
		logic [7:0]     notch_high;
		logic           notch_coeff_update;
	} ctrl_t;
endpackage

// ### codec_ctrl_regs.sv
// register bank and control decode of the stereo codec digital core
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "codec_ctrl_defines.svh"
//
// Contract
// - eight-bit flag puts the audio data path into 8-bit mode
// - playback companding 00 linear, 10 mu-law, 11 A-law, 01 reserved
// - record companding 00 linear, 10 mu-law, 11 A-law, 01 reserved
// - loopback feeds record data straight into the playback path
// - clock source bit, reset 1, picks PLL output or master clock
// - system divider code selects divide by 1 to 12, reset code 010
// - bit clock divider 1 to 32 for codes 000-101, rest reserved
// - master select makes bit and frame clock pins outputs
// - rate field picks filter coefficients 48k down to 8k
// - slow tick enable clocks jack debounce and zero-cross timeout
// - pin one function select with polarity invert
// - jack detection only when enabled, input picked by select field
// - output enables from high mask or low mask by jack level
// - soft mute and automute enables for the playback output
// - oversample bits choose 64x when 0, 128x when 1
// - per channel polarity bits invert playback and record signals
// - playback gains take effect only on an update bit write
// - record gains take effect only on a record update bit write
// - high-pass enable, reset 1, audio or application mode
// - equaliser path select, reset 1, playback when 1
// - limiter enable with decay and attack time codes
// - limiter threshold -1 to -6 dB, boost 0 to +12 dB
module codec_ctrl_regs
	import codec_ctrl_pkg::*;
#(
	parameter int SLOW_DIV  = `SLOW_DIV_DEF,
	parameter int DEB_TICKS = `DEB_TICKS_DEF
)(
	input  wire logic       CORE_CLK,
	input  wire logic       RESET,
	input  wire logic [6:0] ADDR,
	input  wire logic [8:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output var  logic [8:0] RDATA,
	input  wire logic [2:0] JACK_PINS,
	input  wire logic       TEMP_OK,
	input  wire logic       AUTOMUTE_ACTIVE,
	input  wire logic       PLL_CLK,
	input  wire logic       PLL_LOCK,
	output var  logic       GPIO1_OUT,
	output var  logic       GPIO1_OE,
	output var  logic       BCLK_OE,
	output var  logic       LRC_OE,
	output var  logic [3:0] OUT_ENABLES,
	output var  ctrl_t      CTRL
);
	localparam int NREG = IX_NUM;
	localparam logic [6:0] OFS [NREG] = '{`COMPAND_OFS, `CLKGEN_OFS, `RATE_OFS, `PIN_OFS,
		`JDCFG_OFS, `DACCTL_OFS, `PVOLL_OFS, `PVOLR_OFS, `JDMASK_OFS, `ADCCTL_OFS,
		`RVOLL_OFS, `RVOLR_OFS, `EQ1_OFS, `EQ2_OFS, `EQ3_OFS, `EQ4_OFS, `EQ5_OFS,
		`LIMT_OFS, `LIML_OFS, `NOTCH_OFS};
	localparam logic [8:0] MSK [NREG] = '{`COMPAND_MSK, `CLKGEN_MSK, `RATE_MSK, `PIN_MSK,
		`JDCFG_MSK, `DACCTL_MSK, `VOL_MSK, `VOL_MSK, `JDMASK_MSK, `ADCCTL_MSK,
		`VOL_MSK, `VOL_MSK, `EQ_MSK, `EQ_MSK, `EQ_MSK, `EQ_MSK, `EQ5_MSK,
		`LIMT_MSK, `LIML_MSK, `NOTCH_MSK};
	localparam logic [8:0] RST [NREG] = '{`COMPAND_RST, `CLKGEN_RST, `RATE_RST, `PIN_RST,
		`JDCFG_RST, `DACCTL_RST, `VOL_RST, `VOL_RST, `JDMASK_RST, `ADCCTL_RST,
		`VOL_RST, `VOL_RST, `EQ1_RST, `EQ_RST, `EQ_RST, `EQ_RST, `EQ_RST,
		`LIMT_RST, `LIML_RST, `NOTCH_RST};

	logic [8:0]  regs_reg [NREG];
	logic [8:0]  regs_next [NREG];
	logic [NREG-1:0] hit;
	logic [15:0] play_act_reg, play_act_next;
	logic [15:0] rec_act_reg, rec_act_next;
	logic [8:0]  rdata_next;
	logic        notch_upd_reg, notch_upd_next;
	logic [15:0] slow_cnt_reg, slow_cnt_next;
	logic        tick_reg, tick_next;
	logic        jack_raw;
	logic        jack_deb_reg, jack_deb_next;
	logic [3:0]  deb_cnt_reg, deb_cnt_next;
	logic [3:0]  outen_next;
	logic        pll_prev_reg, pll_prev_next;
	logic [1:0]  pll_cnt_reg, pll_cnt_next;
	logic        pll_div_reg, pll_div_next;
	logic        gpio_out_next, gpio_oe_next;
	ctrl_t       ctrl_next;

	// one storage word per mapped offset; reserved bits never stored so they read default
	generate
		for (genvar i = 0; i < NREG; i++)
		begin : g_reg
			assign hit[i] = (ADDR == OFS[i]);
			always_comb
			begin
				regs_next[i] = regs_reg[i];
				if (WR && hit[i])
					regs_next[i] = WDATA & MSK[i];
			end
			always_ff @(posedge CORE_CLK)
			begin
				if (RESET)
					regs_reg[i] <= RST[i];
				else
					regs_reg[i] <= regs_next[i];
			end
		end
	endgenerate

	// shadow to active gain transfer; update bit itself is not stored
	always_comb
	begin
		play_act_next = play_act_reg;
		rec_act_next  = rec_act_reg;
		if (WR && (hit[IX_PVOLL] || hit[IX_PVOLR]) && WDATA[`F_VU])
			play_act_next = {regs_next[IX_PVOLL][`F_GAIN], regs_next[IX_PVOLR][`F_GAIN]};
		if (WR && (hit[IX_RVOLL] || hit[IX_RVOLR]) && WDATA[`F_VU])
			rec_act_next = {regs_next[IX_RVOLL][`F_GAIN], regs_next[IX_RVOLR][`F_GAIN]};
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			play_act_reg <= 16'hFFFF; // both channels at the 8-bit gain default
			rec_act_reg  <= 16'hFFFF;
		end
		else
		begin
			play_act_reg <= play_act_next;
			rec_act_reg  <= rec_act_next;
		end
	end

	// read path: data one cycle after the strobe, zero elsewhere and for unmapped offsets
	always_comb
	begin
		rdata_next = 9'h000;
		if (RD)
		begin
			for (int i = 0; i < NREG; i++)
				if (hit[i])
					rdata_next = regs_reg[i];
			if (ADDR == `STATUS_OFS)
				rdata_next = {3'h0, tick_reg, OUT_ENABLES, jack_deb_reg};
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			RDATA <= 9'h000;
		else
			RDATA <= rdata_next;
	end

	// slow tick divider; it clears to zero while disabled, freezing debounce and timeout
	always_comb
	begin
		slow_cnt_next = 16'h0000;
		tick_next     = 1'b0;
		if (regs_reg[IX_RATE][0])
		begin
			if (slow_cnt_reg == 16'(SLOW_DIV - 1))
				tick_next = 1'b1;
			else
				slow_cnt_next = slow_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			slow_cnt_reg <= 16'h0000;
			tick_reg     <= 1'b0;
		end
		else
		begin
			slow_cnt_reg <= slow_cnt_next;
			tick_reg     <= tick_next;
		end
	end

	// jack debounce counts slow ticks of a steady changed level; reserved select holds
	always_comb
	begin
		jack_raw      = jack_deb_reg;
		if (regs_reg[IX_JDCFG][5:4] != `JACK_INPUT_SEL_RSVD)
			jack_raw = JACK_PINS[regs_reg[IX_JDCFG][5:4]];
		jack_deb_next = jack_deb_reg;
		deb_cnt_next  = deb_cnt_reg;
		if (jack_raw == jack_deb_reg)
			deb_cnt_next = 4'h0;
		else if (tick_reg)
		begin
			if (deb_cnt_reg == 4'(DEB_TICKS - 1))
			begin
				jack_deb_next = jack_raw;
				deb_cnt_next  = 4'h0;
			end
			else
				deb_cnt_next = deb_cnt_reg + 4'h1;
		end
		// disabled detection leaves every output enabled, no switching
		outen_next = 4'hF;
		if (regs_reg[IX_JDCFG][6])
			outen_next = jack_deb_reg ? regs_reg[IX_JDMASK][7:4] : regs_reg[IX_JDMASK][3:0];
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			jack_deb_reg <= 1'b0;
			deb_cnt_reg  <= 4'h0;
			OUT_ENABLES  <= 4'hF;
		end
		else
		begin
			jack_deb_reg <= jack_deb_next;
			deb_cnt_reg  <= deb_cnt_next;
			OUT_ENABLES  <= outen_next;
		end
	end

	// pin one: divider counts both edges of the sampled pll clock, so ratio n divides freq by n
	always_comb
	begin
		pll_prev_next = PLL_CLK;
		pll_cnt_next  = pll_cnt_reg;
		pll_div_next  = pll_div_reg;
		if (PLL_CLK != pll_prev_reg)
		begin
			if (pll_cnt_reg >= regs_reg[IX_PIN][5:4])
			begin
				pll_cnt_next = 2'h0;
				pll_div_next = !pll_div_reg;
			end
			else
				pll_cnt_next = pll_cnt_reg + 2'h1;
		end
		gpio_oe_next  = 1'b1;
		case (regs_reg[IX_PIN][2:0])
			3'h0:    begin gpio_out_next = 1'b0; gpio_oe_next = 1'b0; end
			3'h2:    gpio_out_next = TEMP_OK;
			3'h3:    gpio_out_next = AUTOMUTE_ACTIVE;
			3'h4:    gpio_out_next = pll_div_reg;
			3'h5:    gpio_out_next = PLL_LOCK;
			3'h6:    gpio_out_next = 1'b1;
			default: gpio_out_next = 1'b0;
		endcase
		if (gpio_oe_next && regs_reg[IX_PIN][3])
			gpio_out_next = !gpio_out_next;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			pll_prev_reg <= 1'b0;
			pll_cnt_reg  <= 2'h0;
			pll_div_reg  <= 1'b0;
			GPIO1_OUT    <= 1'b0;
			GPIO1_OE     <= 1'b0;
		end
		else
		begin
			pll_prev_reg <= pll_prev_next;
			pll_cnt_reg  <= pll_cnt_next;
			pll_div_reg  <= pll_div_next;
			GPIO1_OUT    <= gpio_out_next;
			GPIO1_OE     <= gpio_oe_next;
		end
	end

	function automatic compand_t comp_dec(input logic [1:0] code);
		// reserved code falls back to linear rather than an undefined law
		case (code)
			2'h2:    comp_dec = CMP_MU_LAW;
			2'h3:    comp_dec = CMP_A_LAW;
			default: comp_dec = CMP_LINEAR;
		endcase
	endfunction

	// decoded control word, registered so every consumer sees a glitch-free value
	always_comb
	begin
		ctrl_next                       = '0;
		ctrl_next.eight_bit_mode        = regs_reg[IX_COMP][5];
		ctrl_next.play_compand          = comp_dec(regs_reg[IX_COMP][4:3]);
		ctrl_next.rec_compand           = comp_dec(regs_reg[IX_COMP][2:1]);
		ctrl_next.loopback              = regs_reg[IX_COMP][0];
		ctrl_next.core_clock_source_sel = regs_reg[IX_CLK][8];
		ctrl_next.sys_clock_divider     = regs_reg[IX_CLK][7:5];
		ctrl_next.bit_clock_divider     = regs_reg[IX_CLK][4:2];
		ctrl_next.rate_coefficient_sel  = regs_reg[IX_RATE][3:1];
		ctrl_next.slow_tick_enable      = regs_reg[IX_RATE][0];
		ctrl_next.slow_tick             = tick_reg;
		ctrl_next.jack_midrail_enables  = regs_reg[IX_JDCFG][8:7];
		ctrl_next.soft_mute             = regs_reg[IX_DACCTL][6];
		ctrl_next.auto_mute             = regs_reg[IX_DACCTL][2];
		ctrl_next.play_flags            = {regs_reg[IX_DACCTL][3], regs_reg[IX_DACCTL][1:0]};
		ctrl_next.rec_flags             = {regs_reg[IX_ADCCTL][3], regs_reg[IX_ADCCTL][1:0]};
		ctrl_next.playback_left_gain    = play_act_reg[15:8];
		ctrl_next.playback_right_gain   = play_act_reg[7:0];
		ctrl_next.record_left_gain      = rec_act_reg[15:8];
		ctrl_next.record_right_gain     = rec_act_reg[7:0];
		ctrl_next.highpass_enable       = regs_reg[IX_ADCCTL][8];
		ctrl_next.highpass_mode_sel     = regs_reg[IX_ADCCTL][7];
		ctrl_next.highpass_cutoff_sel   = regs_reg[IX_ADCCTL][6:4];
		ctrl_next.eq_path_sel           = regs_reg[IX_EQ1][8];
		for (int b = 0; b < 5; b++)
			ctrl_next.eq_bands[b] = regs_reg[IX_EQ1 + b];
		ctrl_next.limiter_enable        = regs_reg[IX_LIMT][8];
		ctrl_next.limiter_decay_sel     = regs_reg[IX_LIMT][7:4];
		ctrl_next.limiter_attack_sel    = regs_reg[IX_LIMT][3:0];
		ctrl_next.limiter_threshold_db  = (regs_reg[IX_LIML][6:4] >= 3'h5) ? `LIM_LVL_MAX :
			regs_reg[IX_LIML][6:4] + 3'h1;
		// boost stands apart from limiter enable; reserved codes give no boost
		ctrl_next.limiter_gain_boost    = (regs_reg[IX_LIML][3:0] > `LIM_BOOST_MAX) ? 4'h0 :
			regs_reg[IX_LIML][3:0];
		ctrl_next.notch_high            = regs_reg[IX_NOTCH][7:0];
		ctrl_next.notch_coeff_update    = notch_upd_reg;
		notch_upd_next = WR && hit[IX_NOTCH] && WDATA[`F_VU];
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			CTRL          <= '0;
			notch_upd_reg <= 1'b0;
			BCLK_OE       <= 1'b0;
			LRC_OE        <= 1'b0;
		end
		else
		begin
			CTRL          <= ctrl_next;
			notch_upd_reg <= notch_upd_next;
			BCLK_OE       <= regs_reg[IX_CLK][0];
			LRC_OE        <= regs_reg[IX_CLK][0];
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	property p_play_hold;
		WR && hit[IX_PVOLL] && !WDATA[`F_VU] |=> play_act_reg == $past(play_act_reg);
	endproperty
	a_play_hold: assert property (p_play_hold) else $error("gain moved without update");

	property p_play_upd;
		WR && hit[IX_PVOLR] && WDATA[`F_VU] |-> ##2 CTRL.playback_right_gain == $past(WDATA[7:0], 2);
	endproperty
	a_play_upd: assert property (p_play_upd) else $error("right gain not applied");

	property p_rec_upd;
		WR && hit[IX_RVOLL] && WDATA[`F_VU] |-> ##2 CTRL.record_left_gain == $past(WDATA[7:0], 2);
	endproperty
	a_rec_upd: assert property (p_rec_upd) else $error("record gain not applied");

	property p_master;
		WR && hit[IX_CLK] |-> ##2 (BCLK_OE == $past(WDATA[0], 2)) && (LRC_OE == BCLK_OE);
	endproperty
	a_master: assert property (p_master) else $error("clock pin direction wrong");

	property p_jack_off;
		!regs_reg[IX_JDCFG][6] |=> OUT_ENABLES == 4'hF;
	endproperty
	a_jack_off: assert property (p_jack_off) else $error("switching while disabled");

	property p_jack_on;
		regs_reg[IX_JDCFG][6] && !jack_deb_reg |=> OUT_ENABLES == $past(regs_reg[IX_JDMASK][3:0]);
	endproperty
	a_jack_on: assert property (p_jack_on) else $error("low mask not applied");

	property p_pin_high;
		regs_reg[IX_PIN][2:0] == 3'h6 |=> GPIO1_OE && (GPIO1_OUT == !$past(regs_reg[IX_PIN][3]));
	endproperty
	a_pin_high: assert property (p_pin_high) else $error("pin logic one wrong");

	property p_slow_off;
		!regs_reg[IX_RATE][0] [*2] |-> ##1 !tick_reg && !CTRL.slow_tick;
	endproperty
	a_slow_off: assert property (p_slow_off) else $error("tick while disabled");

	property p_thresh;
		regs_reg[IX_LIML][6:4] >= 3'h5 |=> CTRL.limiter_threshold_db == `LIM_LVL_MAX;
	endproperty
	a_thresh: assert property (p_thresh) else $error("threshold clamp wrong");

	property p_comp;
		regs_reg[IX_COMP][4:3] == 2'h1 |=> CTRL.play_compand == CMP_LINEAR;
	endproperty
	a_comp: assert property (p_comp) else $error("reserved companding not linear");

	c_play_upd: cover property (WR && hit[IX_PVOLL] && WDATA[`F_VU] ##2 CTRL.playback_left_gain != 8'hFF);
	c_jack_sw:  cover property (regs_reg[IX_JDCFG][6] && $changed(jack_deb_reg));
	c_read:     cover property (RD && hit[IX_CLK] ##1 RDATA == `CLKGEN_RST);
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the codec control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	import codec_ctrl_pkg::*;
	logic       core_clk;
	logic       reset;
	logic [6:0] addr;
	logic [8:0] wdata;
	logic       wr_s;
	logic       rd_s;
	logic [8:0] rdata;
	logic [2:0] jack_pins;
	logic       temp_ok;
	logic       automute_active;
	logic       pll_clk;
	logic       pll_lock;
	logic       gpio1_out;
	logic       gpio1_oe;
	logic       bclk_oe;
	logic       lrc_oe;
	logic [3:0] out_enables;
	ctrl_t      ctrl;
	int         failures;
	int         num_checks;
	int         cycles;
	logic [8:0] d;
	int         toggles;
	// offset, reset value and writable bits of every mapped register
	logic [6:0] ofs_tab [20] = '{7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h0D,
		7'h0E, 7'h0F, 7'h10, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h18, 7'h19, 7'h1B};
	logic [8:0] rst_tab [20] = '{9'h000, 9'h140, 9'h000, 9'h000, 9'h000, 9'h000, 9'h0FF, 9'h0FF,
		9'h000, 9'h100, 9'h0FF, 9'h0FF, 9'h12C, 9'h02C, 9'h02C, 9'h02C, 9'h02C, 9'h032, 9'h000, 9'h000};
	logic [8:0] msk_tab [20] = '{9'h03F, 9'h1FD, 9'h00F, 9'h03F, 9'h1F0, 9'h04F, 9'h0FF, 9'h0FF,
		9'h0FF, 9'h1FB, 9'h0FF, 9'h0FF, 9'h17F, 9'h17F, 9'h17F, 9'h17F, 9'h07F, 9'h1FF, 9'h07F, 9'h0FF};
	// pin one drive value per function code with temp ok 1, automute 0, lock 1
	logic       pin_exp [8] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	compand_t   cmp_exp [4] = '{CMP_LINEAR, CMP_LINEAR, CMP_MU_LAW, CMP_A_LAW};

	// short slow-tick divider and debounce keep the jack tests quick
	codec_ctrl_regs #(
		.SLOW_DIV  (4),
		.DEB_TICKS (2)
	) u_dut (
		.CORE_CLK        (core_clk),
		.RESET           (reset),
		.ADDR            (addr),
		.WDATA           (wdata),
		.WR              (wr_s),
		.RD              (rd_s),
		.RDATA           (rdata),
		.JACK_PINS       (jack_pins),
		.TEMP_OK         (temp_ok),
		.AUTOMUTE_ACTIVE (automute_active),
		.PLL_CLK         (pll_clk),
		.PLL_LOCK        (pll_lock),
		.GPIO1_OUT       (gpio1_out),
		.GPIO1_OE        (gpio1_oe),
		.BCLK_OE         (bclk_oe),
		.LRC_OE          (lrc_oe),
		.OUT_ENABLES     (out_enables),
		.CTRL            (ctrl)
	);

	// 100 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// sampled pll clock toggles every core cycle
	always @(posedge core_clk)
	begin
		pll_clk <= ~pll_clk;
	end

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			results();
		end
	end

	// wide enough for a left/right gain pair
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [8:0] v);
		@(posedge core_clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge core_clk);
		wr_s <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [6:0] a, output logic [8:0] v);
		@(posedge core_clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge core_clk);
		rd_s <= 1'b0;
		#1;
		v = rdata;
	endtask

	// decoded outputs lag a write by two cycles
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic do_reset();
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
	endtask

	task automatic reset_values();
		for (int i = 0; i < 20; i++)
		begin
			rd(ofs_tab[i], d);
			check(d, rst_tab[i]);
		end
	endtask

	task automatic results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		reset = 1'b1;
		addr = 7'h00;
		wdata = 9'h000;
		wr_s = 1'b0;
		rd_s = 1'b0;
		jack_pins = 3'h0;
		temp_ok = 1'b1;
		automute_active = 1'b0;
		pll_clk = 1'b0;
		pll_lock = 1'b1;
		failures = 0;
		num_checks = 0;
		cycles = 0;
		do_reset();
		reset_values();
		check({ctrl.core_clock_source_sel, ctrl.highpass_enable, ctrl.eq_path_sel}, 9'h007);
		check({ctrl.sys_clock_divider, ctrl.limiter_decay_sel}, 9'h023);
		check(ctrl.record_right_gain, 9'h0FF);
		// all ones everywhere: reserved bits must stay clear
		for (int i = 0; i < 20; i++)
		begin
			wr(ofs_tab[i], 9'h1FF);
			rd(ofs_tab[i], d);
			check(d, msk_tab[i]);
		end
		settle(1);
		check(rdata, 9'h000);
		wr(7'h01, 9'h1FF);
		rd(7'h01, d);
		check(d, 9'h000);
		rd(7'h11, d);
		check(d, 9'h000);
		// second reset in mid-run restores every default
		do_reset();
		reset_values();
		// companding codes for both directions
		for (int i = 0; i < 4; i++)
		begin
			wr(7'h05, {3'h0, 1'b0, i[1:0], i[1:0], 1'b0});
			settle(3);
			check(ctrl.play_compand, cmp_exp[i]);
			check(ctrl.rec_compand, cmp_exp[i]);
		end
		wr(7'h05, 9'h021);
		settle(3);
		check({ctrl.eight_bit_mode, ctrl.loopback}, 9'h003);
		// clock source, dividers, master select, rate codes
		for (int i = 0; i < 8; i++)
		begin
			wr(7'h06, {i[0], i[2:0], i[2:0], 1'b0, i[0]});
			wr(7'h07, {5'h00, i[2:0], 1'b0});
			settle(3);
			check(ctrl.core_clock_source_sel, i[0]);
			check({ctrl.sys_clock_divider, ctrl.bit_clock_divider}, {3'h0, i[2:0], i[2:0]});
			check({bclk_oe, lrc_oe}, {7'h00, i[0], i[0]});
			check(ctrl.rate_coefficient_sel, i[2:0]);
		end
		// pin one functions other than the divided pll clock
		for (int i = 0; i < 8; i++)
		begin
			if (i == 4)
				continue;
			wr(7'h08, {6'h00, i[2:0]});
			settle(3);
			check(gpio1_oe, (i != 0));
			if (i != 0)
				check(gpio1_out, pin_exp[i]);
		end
		wr(7'h08, 9'h00E);
		settle(3);
		check(gpio1_out, 1'b0);
		// temp ok and automute inputs flipped so a stuck wire shows
		temp_ok <= 1'b0;
		automute_active <= 1'b1;
		wr(7'h08, 9'h003);
		settle(3);
		check(gpio1_out, 1'b1);
		wr(7'h08, 9'h002);
		settle(3);
		check(gpio1_out, 1'b0);
		// pll clock changes every cycle: ratio 1 toggles 16 times, ratio 2 eight
		for (int k = 0; k < 2; k++)
		begin
			wr(7'h08, {3'h0, k[1:0], 4'h4});
			settle(3);
			toggles = 0;
			d[0] = gpio1_out;
			for (int i = 0; i < 16; i++)
			begin
				settle(1);
				if (gpio1_out !== d[0])
					toggles++;
				d[0] = gpio1_out;
			end
			check(toggles[15:0], (k == 0) ? 16'h0010 : 16'h0008);
		end
		// mute, oversampling and polarity bits
		wr(7'h0A, 9'h04F);
		settle(3);
		check({ctrl.soft_mute, ctrl.auto_mute, ctrl.play_flags}, 9'h01F);
		wr(7'h0A, 9'h042);
		settle(3);
		check({ctrl.soft_mute, ctrl.auto_mute, ctrl.play_flags}, 9'h012);
		wr(7'h0E, 9'h0D9);
		settle(3);
		check({ctrl.highpass_enable, ctrl.highpass_mode_sel, ctrl.highpass_cutoff_sel}, 9'h00D);
		check(ctrl.rec_flags, 9'h005);
		wr(7'h12, 9'h02C);
		settle(3);
		check(ctrl.eq_path_sel, 1'b0);
		// gains wait in shadow until an update write moves both
		wr(7'h0B, 9'h040);
		settle(3);
		check(ctrl.playback_left_gain, 9'h0FF);
		wr(7'h0C, 9'h120);
		settle(3);
		check({ctrl.playback_left_gain, ctrl.playback_right_gain}, 16'h4020);
		wr(7'h10, 9'h055);
		wr(7'h0F, 9'h1AA);
		settle(3);
		check({ctrl.record_left_gain, ctrl.record_right_gain}, 16'hAA55);
		// limiter codes including the clamped ones
		wr(7'h19, 9'h05D);
		wr(7'h18, 9'h1A7);
		settle(3);
		check({ctrl.limiter_threshold_db, ctrl.limiter_gain_boost}, 9'h060);
		check({ctrl.limiter_enable, ctrl.limiter_decay_sel, ctrl.limiter_attack_sel}, 9'h1A7);
		wr(7'h19, 9'h00C);
		settle(3);
		check({ctrl.limiter_threshold_db, ctrl.limiter_gain_boost}, 9'h01C);
		// jack switching on pin two, then pin three, then disabled
		wr(7'h0D, 9'h0A5);
		wr(7'h09, 9'h050);
		wr(7'h07, 9'h001);
		jack_pins <= 3'b010;
		settle(30);
		check(out_enables, 4'hA);
		rd(7'h3F, d);
		check(d[4:0], 5'h15);
		jack_pins <= 3'b000;
		settle(30);
		check(out_enables, 4'h5);
		wr(7'h09, 9'h060);
		jack_pins <= 3'b100;
		settle(30);
		check(out_enables, 4'hA);
		wr(7'h09, 9'h000);
		settle(3);
		check(out_enables, 4'hF);
		// without slow ticks the debounce must not advance
		wr(7'h09, 9'h050);
		settle(30);
		check(out_enables, 4'h5);
		wr(7'h07, 9'h000);
		jack_pins <= 3'b010;
		settle(30);
		check(out_enables, 4'h5);
		results();
	end
endmodule
`default_nettype wire
